/* serial_port_loss_supervisor_pkg.sv */
// Purpose: Constants and types of the serial port loss supervisor.
// Assumes: 100 MHz system clock, 16-bit register data.
// Notes: Offsets are register indices on the plain register port.
package serial_port_loss_supervisor_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int LOSS_STEP_MS = 100;
    localparam int LOSS_STEP_CYC = CLK_HZ / 1000 * LOSS_STEP_MS;
    localparam logic [9:0] LOSS_TIME_MIN = 10'h001;
    localparam logic [9:0] LOSS_TIME_MAX = 10'h258;
    localparam int ERR_LIMIT_DEF = 8;

    // ****************************************************************
    // Bit rates
    // ****************************************************************
    localparam int BAUD_0 = 1200;
    localparam int BAUD_1 = 2400;
    localparam int BAUD_2 = 4800;
    localparam int BAUD_3 = 9600;
    localparam int BAUD_4 = 19200;
    localparam int BAUD_5 = 38400;
    localparam logic [2:0] RATE_CODE_MAX = 3'h5;
    localparam logic [2:0] FMT_CODE_MAX = 3'h5;
    localparam logic [7:0] NODE_ADDR_MIN = 8'h01;
    localparam logic [7:0] NODE_ADDR_MAX = 8'hf7;

    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [3:0] REG_RATE = 4'h0;
    localparam logic [3:0] REG_NODE = 4'h1;
    localparam logic [3:0] REG_ACTION = 4'h2;
    localparam logic [3:0] REG_TIMEOUT = 4'h3;
    localparam logic [3:0] REG_FORMAT = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_ACT_ADDR = 4'h6;
    localparam logic [3:0] REG_INT_STAT = 4'h7;
    localparam logic [3:0] REG_INT_MASK = 4'h8;
    localparam logic [3:0] REG_CONTROL = 4'h9;
    localparam logic [3:0] REG_SPEED = 4'ha;

    // ****************************************************************
    // Reset values and fields
    // ****************************************************************
    localparam logic [2:0] RATE_RST = 3'h3;
    localparam logic [7:0] NODE_RST = 8'h64;
    localparam logic [9:0] TIMEOUT_RST = 10'h032;
    localparam logic [2:0] FORMAT_RST = 3'h0;
    localparam int INT_LOSS_BIT = 0;
    localparam int INT_ERR_BIT = 1;
    localparam int INT_BACK_BIT = 2;
    localparam int CTRL_CLR_FAULT_BIT = 0;

    typedef enum logic [1:0] {
        ACT_FAULT = 2'b00,
        ACT_COAST = 2'b01,
        ACT_STOP = 2'b10,
        ACT_HOLD = 2'b11
    } loss_action_t;

    typedef enum logic {
        LINK_OK = 1'b0,
        LINK_LOST = 1'b1
    } link_state_t;

endpackage

/* serial_port_loss_supervisor.sv */
// Purpose: Port settings and loss supervision of a multidrop serial node.
// Assumes: All inputs synchronous to I_SYS_CLK.
// Notes: The frame decoder outside reports frames as one-cycle pulses.
`timescale 1ns/100ps
module serial_port_loss_supervisor
    import serial_port_loss_supervisor_pkg::*;
#(
    parameter int TICK_CYCLES = LOSS_STEP_CYC,
    parameter int ERR_LIMIT = ERR_LIMIT_DEF
) (
    input wire logic I_SYS_CLK, // System clock
    input wire logic I_RST_N, // Synchronous reset
    input wire logic I_POWER_UP, // Power-up latch pulse
    input wire logic [3:0] I_ADDR, // Register index
    input wire logic [15:0] I_WDATA, // Write data
    input wire logic I_WR, // Write strobe
    input wire logic I_RD, // Read strobe
    input wire logic I_FRAME_OK, // Good frame pulse
    input wire logic [7:0] I_FRAME_ADDR, // Address of that frame
    input wire logic I_FRAME_ERR, // Bad frame pulse
    input wire logic I_SPEED_VALID, // Link speed command pulse
    input wire logic [15:0] I_SPEED_CMD, // Link speed command
    output logic [15:0] O_RDATA, // Read data
    output logic [16:0] O_BIT_CYCLES, // Clock cycles per bit
    output logic O_PARITY_EN, // Parity bit present
    output logic O_PARITY_ODD, // Odd parity
    output logic O_TWO_STOP, // Two stop bits
    output logic [7:0] O_NODE_ADDR, // Active node address
    output logic O_COAST_STOP, // Coast to stop
    output logic O_RAMP_STOP, // Stop by configured_stop_method
    output logic O_HOLD_SPEED, // Keep last link speed
    output logic [15:0] O_SPEED_REF, // Last link speed
    output logic O_LINK_LOSS_FAULT, // link_loss_fault
    output logic O_LOSS_ACTIVE, // Loss action applied
    output logic O_IRQ // Interrupt, level
);

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    generate
        if (TICK_CYCLES < 1 || ERR_LIMIT < 1 || ERR_LIMIT > 255) begin
            $error("TICK_CYCLES or ERR_LIMIT out of range.");
        end
    endgenerate

    localparam logic [7:0] ERR_LIM = 8'(ERR_LIMIT);
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    // ****************************************************************
    // Bit period table
    // ****************************************************************
    function automatic logic [16:0] bit_cycles(input logic [2:0] code);
        logic [16:0] c;
        c = 17'(CLK_HZ / BAUD_3);
        unique case (code)
            3'h0: c = 17'(CLK_HZ / BAUD_0);
            3'h1: c = 17'(CLK_HZ / BAUD_1);
            3'h2: c = 17'(CLK_HZ / BAUD_2);
            3'h3: c = 17'(CLK_HZ / BAUD_3);
            3'h4: c = 17'(CLK_HZ / BAUD_4);
            3'h5: c = 17'(CLK_HZ / BAUD_5);
            default: c = 17'(CLK_HZ / BAUD_3);
        endcase
        return c;
    endfunction

    // ****************************************************************
    // Software settings
    // ****************************************************************
    logic [2:0] rate_r;
    logic [7:0] node_r;
    loss_action_t action_r;
    logic [9:0] timeout_r;
    logic [2:0] format_r;
    logic [2:0] int_mask_r;
    logic wr_clr_fault;
    logic [7:0] node_nxt;
    logic [9:0] timeout_nxt;

    assign wr_clr_fault = I_WR && I_ADDR == REG_CONTROL
        && I_WDATA[CTRL_CLR_FAULT_BIT];

    // Out-of-range address and time are pulled to the nearest limit.
    always_comb begin
        node_nxt = I_WDATA[7:0];
        if (I_WDATA[15:8] != 8'h00 || I_WDATA[7:0] > NODE_ADDR_MAX) begin
            node_nxt = NODE_ADDR_MAX;
        end else if (I_WDATA[7:0] < NODE_ADDR_MIN) begin
            node_nxt = NODE_ADDR_MIN;
        end
        timeout_nxt = I_WDATA[9:0];
        if (I_WDATA[15:10] != 6'h00 || I_WDATA[9:0] > LOSS_TIME_MAX) begin
            timeout_nxt = LOSS_TIME_MAX;
        end else if (I_WDATA[9:0] < LOSS_TIME_MIN) begin
            timeout_nxt = LOSS_TIME_MIN;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            rate_r <= RATE_RST;
            node_r <= NODE_RST;
            action_r <= ACT_FAULT;
            timeout_r <= TIMEOUT_RST;
            format_r <= FORMAT_RST;
            int_mask_r <= 3'h0;
        end else if (I_WR) begin
            unique case (I_ADDR)
                REG_RATE: begin
                    if (I_WDATA[2:0] <= RATE_CODE_MAX) begin
                        rate_r <= I_WDATA[2:0];
                    end
                end
                REG_NODE: node_r <= node_nxt;
                REG_ACTION: action_r <= loss_action_t'(I_WDATA[1:0]);
                REG_TIMEOUT: timeout_r <= timeout_nxt;
                REG_FORMAT: begin
                    if (I_WDATA[2:0] <= FMT_CODE_MAX) begin
                        format_r <= I_WDATA[2:0];
                    end
                end
                REG_INT_MASK: int_mask_r <= I_WDATA[2:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Settings latched at power-up
    // ****************************************************************
    logic [2:0] act_rate_r;
    logic [2:0] act_fmt_r;
    logic latched_r;
    logic do_latch;

    // The first cycle after reset counts as a power-up as well.
    assign do_latch = I_POWER_UP || !latched_r;

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            latched_r <= 1'b0;
            act_rate_r <= RATE_RST;
            act_fmt_r <= FORMAT_RST;
            O_NODE_ADDR <= NODE_RST;
        end else begin
            latched_r <= 1'b1;
            if (do_latch) begin
                act_rate_r <= rate_r;
                act_fmt_r <= format_r;
                O_NODE_ADDR <= node_r;
            end
        end
    end

    // ****************************************************************
    // Character format outputs
    // ****************************************************************
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            O_BIT_CYCLES <= bit_cycles(RATE_RST);
            O_PARITY_EN <= 1'b0;
            O_PARITY_ODD <= 1'b0;
            O_TWO_STOP <= 1'b0;
        end else begin
            O_BIT_CYCLES <= bit_cycles(act_rate_r);
            unique case (act_fmt_r)
                3'h1, 3'h4: begin
                    O_PARITY_EN <= 1'b1;
                    O_PARITY_ODD <= 1'b0;
                end
                3'h2, 3'h5: begin
                    O_PARITY_EN <= 1'b1;
                    O_PARITY_ODD <= 1'b1;
                end
                default: begin
                    O_PARITY_EN <= 1'b0;
                    O_PARITY_ODD <= 1'b0;
                end
            endcase
            O_TWO_STOP <= act_fmt_r >= 3'h3;
        end
    end

    // ****************************************************************
    // Traffic and error tracking
    // ****************************************************************
    logic frame_mine;
    logic [7:0] err_cnt_r;
    logic err_cond_r;

    assign frame_mine = I_FRAME_OK && I_FRAME_ADDR == O_NODE_ADDR;

    // Errors count while no good frame for this node arrives.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            err_cnt_r <= 8'h00;
            err_cond_r <= 1'b0;
        end else if (frame_mine) begin
            err_cnt_r <= 8'h00;
            err_cond_r <= 1'b0;
        end else if (I_FRAME_ERR && err_cnt_r != ERR_LIM) begin
            err_cnt_r <= err_cnt_r + 8'h01;
            err_cond_r <= err_cnt_r + 8'h01 == ERR_LIM;
        end
    end

    // ****************************************************************
    // Loss timer
    // ****************************************************************
    logic [31:0] tick_cnt_r;
    logic [9:0] tenth_cnt_r;
    logic tick;
    logic expired;

    assign tick = tick_cnt_r == TICK_LAST;
    assign expired = tenth_cnt_r >= timeout_r;

    // Silence, or a frame stream of nothing but errors, is a loss.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            tick_cnt_r <= 32'h0;
            tenth_cnt_r <= 10'h000;
        end else if (frame_mine) begin
            tick_cnt_r <= 32'h0;
            tenth_cnt_r <= 10'h000;
        end else if (err_cond_r) begin
            tick_cnt_r <= 32'h0;
            tenth_cnt_r <= LOSS_TIME_MAX;
        end else if (tick) begin
            tick_cnt_r <= 32'h0;
            if (tenth_cnt_r != LOSS_TIME_MAX) begin
                tenth_cnt_r <= tenth_cnt_r + 10'h001;
            end
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    // ****************************************************************
    // Link state and loss response
    // ****************************************************************
    link_state_t state_r;
    logic loss_fire;
    logic link_back;

    assign loss_fire = state_r == LINK_OK && expired && !frame_mine;
    assign link_back = state_r == LINK_LOST && frame_mine;

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            state_r <= LINK_OK;
        end else begin
            unique case (state_r)
                LINK_OK: if (loss_fire) state_r <= LINK_LOST;
                LINK_LOST: if (frame_mine) state_r <= LINK_OK;
            endcase
        end
    end

    // The action is sampled when the loss fires and held until a good frame for this node.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            O_COAST_STOP <= 1'b0;
            O_RAMP_STOP <= 1'b0;
            O_HOLD_SPEED <= 1'b0;
            O_LOSS_ACTIVE <= 1'b0;
        end else if (loss_fire) begin
            O_LOSS_ACTIVE <= 1'b1;
            O_COAST_STOP <= action_r == ACT_FAULT
                || action_r == ACT_COAST;
            O_RAMP_STOP <= action_r == ACT_STOP;
            O_HOLD_SPEED <= action_r == ACT_HOLD;
        end else if (link_back) begin
            O_LOSS_ACTIVE <= 1'b0;
            O_COAST_STOP <= 1'b0;
            O_RAMP_STOP <= 1'b0;
            O_HOLD_SPEED <= 1'b0;
        end
    end

    // The fault stays until software clears it; a new loss wins.
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            O_LINK_LOSS_FAULT <= 1'b0;
        end else if (loss_fire && action_r == ACT_FAULT) begin
            O_LINK_LOSS_FAULT <= 1'b1;
        end else if (wr_clr_fault) begin
            O_LINK_LOSS_FAULT <= 1'b0;
        end
    end

    // ****************************************************************
    // Last commanded speed
    // ****************************************************************
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            O_SPEED_REF <= 16'h0000;
        end else if (I_SPEED_VALID) begin
            O_SPEED_REF <= I_SPEED_CMD;
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    logic [2:0] int_stat_r;
    logic [2:0] int_set;
    logic [2:0] int_clr;

    assign int_set = {link_back,
        I_FRAME_ERR && err_cnt_r + 8'h01 == ERR_LIM, loss_fire};
    assign int_clr = (I_WR && I_ADDR == REG_INT_STAT)
        ? I_WDATA[2:0] : 3'h0;

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            int_stat_r <= 3'h0;
        end else begin
            int_stat_r <= (int_stat_r & ~int_clr) | int_set;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= |(((int_stat_r & ~int_clr) | int_set) & int_mask_r);
        end
    end

    // ****************************************************************
    // Register read
    // ****************************************************************
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            O_RDATA <= 16'h0000;
        end else if (I_RD) begin
            unique case (I_ADDR)
                REG_RATE: O_RDATA <= {13'h0, rate_r};
                REG_NODE: O_RDATA <= {8'h00, node_r};
                REG_ACTION: O_RDATA <= {14'h0, action_r};
                REG_TIMEOUT: O_RDATA <= {6'h00, timeout_r};
                REG_FORMAT: O_RDATA <= {13'h0, format_r};
                REG_STATUS: O_RDATA <= {7'h00, act_fmt_r, act_rate_r,
                    err_cond_r, O_LINK_LOSS_FAULT, O_LOSS_ACTIVE};
                REG_ACT_ADDR: O_RDATA <= {8'h00, O_NODE_ADDR};
                REG_INT_STAT: O_RDATA <= {13'h0, int_stat_r};
                REG_INT_MASK: O_RDATA <= {13'h0, int_mask_r};
                REG_SPEED: O_RDATA <= O_SPEED_REF;
                default: O_RDATA <= 16'h0000;
            endcase
        end else begin
            O_RDATA <= 16'h0000;
        end
    end

endmodule

/* serial_port_loss_supervisor_sva.sv */
// Purpose: Port assertions of the serial port loss supervisor.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Bound to the design from the bench top file.
`timescale 1ns/100ps
module serial_port_loss_supervisor_sva
    import serial_port_loss_supervisor_pkg::*;
#(
    parameter int TICK_CYCLES = LOSS_STEP_CYC,
    parameter int ERR_LIMIT = ERR_LIMIT_DEF
) (
    input wire logic I_SYS_CLK, // Clock
    input wire logic I_RST_N, // Reset
    input wire logic I_POWER_UP, // Latch pulse
    input wire logic I_FRAME_OK, // Good frame
    input wire logic [7:0] I_FRAME_ADDR, // Frame address
    input wire logic I_FRAME_ERR, // Bad frame
    input wire logic [16:0] O_BIT_CYCLES, // Bit time
    input wire logic O_PARITY_EN, // Parity on
    input wire logic O_PARITY_ODD, // Odd parity
    input wire logic O_TWO_STOP, // Two stops
    input wire logic [7:0] O_NODE_ADDR, // Node
    input wire logic O_COAST_STOP, // Coast
    input wire logic O_RAMP_STOP, // Ramp
    input wire logic O_HOLD_SPEED, // Hold
    input wire logic O_LINK_LOSS_FAULT, // Fault
    input wire logic O_LOSS_ACTIVE // Loss
);
    logic own;
    logic [31:0] quiet_r;
    logic [7:0] errs_r;

    // ************
    // Quiet time and errors since the last frame for this node.
    // ************
    assign own = I_FRAME_OK && (I_FRAME_ADDR == O_NODE_ADDR);
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N || own) begin
            quiet_r <= '0;
            errs_r <= '0;
        end else begin
            if (quiet_r != 32'hffffffff) quiet_r <= quiet_r + 32'h1;
            if (I_FRAME_ERR && errs_r != 8'hff) errs_r <= errs_r + 8'h1;
        end
    end

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_N);

    a_port_latch: assert property (
        $changed({O_BIT_CYCLES, O_NODE_ADDR, O_PARITY_EN, O_PARITY_ODD,
        O_TWO_STOP}) |-> $past(I_POWER_UP) || $past(I_POWER_UP, 2))
        else $error("port setting changed without power-up");
    a_rate_legal: assert property (
        O_BIT_CYCLES inside {17'h14585, 17'h0a2c2, 17'h05161, 17'h028b0,
        17'h01458, 17'h00a2c}) else $error("bit time not a listed rate");
    a_node_range: assert property (
        O_NODE_ADDR inside {[8'h01:8'hf7]}) else $error("node out of range");
    a_parity_form: assert property (
        O_PARITY_ODD |-> O_PARITY_EN) else $error("odd parity without parity");
    a_fault_coast: assert property (
        $rose(O_LINK_LOSS_FAULT) |-> O_COAST_STOP && O_LOSS_ACTIVE)
        else $error("fault without coast stop");
    a_hold_nofault: assert property (
        $rose(O_HOLD_SPEED) |-> !$rose(O_LINK_LOSS_FAULT) && !O_COAST_STOP
        && !O_RAMP_STOP) else $error("hold came with a stop or fault");
    a_loss_wait: assert property (
        $rose(O_LOSS_ACTIVE) |-> quiet_r >= TICK_CYCLES || errs_r >= ERR_LIMIT)
        else $error("loss applied too early");
    a_frame_revive: assert property (
        own |-> ##[1:2] !O_LOSS_ACTIVE) else $error("loss kept after frame");
endmodule

/* net_master_model.sv */
// Purpose: Network master that hands decoded frames to the node.
// Assumes: Commands from the bench last one cycle.
// Notes: Idle address and speed lines show the inverse of the last value.
`timescale 1ns/100ps
module net_master_model (
    input wire logic i_clk, // Clock
    input wire logic i_rst_n, // Reset
    input wire logic i_send, // Send one frame
    input wire logic i_bad, // Frame is corrupt
    input wire logic [7:0] i_dest, // Destination node
    input wire logic [15:0] i_spd, // Speed carried
    output logic o_frame_ok, // Good frame
    output logic o_frame_err, // Bad frame
    output logic [7:0] o_frame_addr, // Frame address
    output logic o_spd_valid, // Speed strobe
    output logic [15:0] o_spd // Speed value
);
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_frame_ok <= 1'b0;
            o_frame_err <= 1'b0;
            o_spd_valid <= 1'b0;
            o_frame_addr <= 8'h00;
            o_spd <= 16'h0000;
        end else begin
            o_frame_ok <= i_send && !i_bad;
            o_frame_err <= i_send && i_bad;
            o_spd_valid <= i_send && !i_bad;
            o_frame_addr <= i_send ? i_dest : ~o_frame_addr;
            o_spd <= i_send ? i_spd : ~o_spd;
        end
    end
endmodule

/* serial_port_loss_supervisor_bench.sv */
// Purpose: Self-checking bench of the serial port loss supervisor.
// Assumes: Short loss tick so timeouts last a few cycles.
// Notes: Frames come from the network master model.
`timescale 1ns/100ps
module serial_port_loss_supervisor_bench;
    import serial_port_loss_supervisor_pkg::*;
    localparam int TICK = 4;
    localparam int ERRL = 3;
    logic I_SYS_CLK, I_RST_N, I_POWER_UP, I_WR, I_RD;
    logic [3:0] I_ADDR;
    logic [15:0] I_WDATA, I_SPEED_CMD, O_RDATA, O_SPEED_REF, m_spd;
    logic I_FRAME_OK, I_FRAME_ERR, I_SPEED_VALID, m_send, m_bad;
    logic [7:0] I_FRAME_ADDR, O_NODE_ADDR, m_dest;
    logic [16:0] O_BIT_CYCLES;
    logic O_PARITY_EN, O_PARITY_ODD, O_TWO_STOP, O_COAST_STOP, O_RAMP_STOP;
    logic O_HOLD_SPEED, O_LINK_LOSS_FAULT, O_LOSS_ACTIVE, O_IRQ;
    logic [2:0] fmt3;
    logic [5:0] resp;
    logic [16:0] bc [6];
    int failures, compares, cycles;

    assign fmt3 = {O_PARITY_EN, O_PARITY_ODD, O_TWO_STOP};
    assign resp = {O_LOSS_ACTIVE, O_IRQ, O_LINK_LOSS_FAULT, O_COAST_STOP,
        O_RAMP_STOP, O_HOLD_SPEED};
    serial_port_loss_supervisor #(.TICK_CYCLES(TICK), .ERR_LIMIT(ERRL)) dut (
        .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_POWER_UP(I_POWER_UP),
        .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
        .I_FRAME_OK(I_FRAME_OK), .I_FRAME_ADDR(I_FRAME_ADDR),
        .I_FRAME_ERR(I_FRAME_ERR), .I_SPEED_VALID(I_SPEED_VALID),
        .I_SPEED_CMD(I_SPEED_CMD), .O_RDATA(O_RDATA),
        .O_BIT_CYCLES(O_BIT_CYCLES), .O_PARITY_EN(O_PARITY_EN),
        .O_PARITY_ODD(O_PARITY_ODD), .O_TWO_STOP(O_TWO_STOP),
        .O_NODE_ADDR(O_NODE_ADDR), .O_COAST_STOP(O_COAST_STOP),
        .O_RAMP_STOP(O_RAMP_STOP), .O_HOLD_SPEED(O_HOLD_SPEED),
        .O_SPEED_REF(O_SPEED_REF), .O_LINK_LOSS_FAULT(O_LINK_LOSS_FAULT),
        .O_LOSS_ACTIVE(O_LOSS_ACTIVE), .O_IRQ(O_IRQ));
    net_master_model master (.i_clk(I_SYS_CLK), .i_rst_n(I_RST_N),
        .i_send(m_send), .i_bad(m_bad), .i_dest(m_dest), .i_spd(m_spd),
        .o_frame_ok(I_FRAME_OK), .o_frame_err(I_FRAME_ERR),
        .o_frame_addr(I_FRAME_ADDR), .o_spd_valid(I_SPEED_VALID),
        .o_spd(I_SPEED_CMD));

    // ************
    // Clock, hang limit and shared tasks.
    // ************
    initial begin
        I_SYS_CLK = 1'b0;
        forever #5 I_SYS_CLK = ~I_SYS_CLK;
    end
    always @(posedge I_SYS_CLK) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge I_SYS_CLK);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'b1;
        @(posedge I_SYS_CLK);
        I_WR <= 1'b0;
        @(posedge I_SYS_CLK);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        I_ADDR <= a;
        I_RD <= 1'b1;
        @(posedge I_SYS_CLK);
        I_RD <= 1'b0;
        #1;
        check({1'b0, O_RDATA}, {1'b0, exp});
        @(posedge I_SYS_CLK);
    endtask
    task automatic send(input logic [7:0] d, input logic b,
        input logic [15:0] s);
        m_send <= 1'b1;
        m_dest <= d;
        m_bad <= b;
        m_spd <= s;
        @(posedge I_SYS_CLK);
        m_send <= 1'b0;
        tick(1);
    endtask
    task automatic pwr();
        I_POWER_UP <= 1'b1;
        @(posedge I_SYS_CLK);
        I_POWER_UP <= 1'b0;
        tick(3);
    endtask

    // ************
    // Test sequence.
    // ************
    initial begin
        bc = '{17'h14585, 17'h0a2c2, 17'h05161, 17'h028b0, 17'h01458,
            17'h00a2c};
        I_RST_N = 1'b0;
        I_POWER_UP = 1'b0;
        I_WR = 1'b0;
        I_RD = 1'b0;
        I_ADDR = 4'h0;
        I_WDATA = 16'h0000;
        m_send = 1'b0;
        m_bad = 1'b0;
        m_dest = 8'h00;
        m_spd = 16'h0000;
        repeat (3) @(posedge I_SYS_CLK);
        I_RST_N <= 1'b1;
        tick(1);
        rd(REG_RATE, 16'h0003);
        rd(REG_NODE, 16'h0064);
        rd(REG_ACTION, 16'h0000);
        rd(REG_TIMEOUT, 16'h0032);
        rd(REG_FORMAT, 16'h0000);
        rd(4'hf, 16'h0000);
        check(O_BIT_CYCLES, bc[3]);
        wr(REG_NODE, 16'h0100);
        rd(REG_NODE, 16'h00f7);
        wr(REG_NODE, 16'h0000);
        rd(REG_NODE, 16'h0001);
        wr(REG_NODE, 16'h0005);
        tick(2);
        check({9'h0, O_NODE_ADDR}, 17'h00064);
        for (int i = 0; i < 6; i++) begin
            wr(REG_RATE, 16'(i));
            wr(REG_FORMAT, 16'(i));
            tick(2);
            check(O_BIT_CYCLES, bc[i == 0 ? 3 : i - 1]);
            pwr();
            check(O_BIT_CYCLES, bc[i]);
            check(17'(fmt3), {14'h0, i % 3 != 0, i % 3 == 2, i > 2});
        end
        check({9'h0, O_NODE_ADDR}, 17'h00005);
        wr(REG_RATE, 16'h0006);
        wr(REG_FORMAT, 16'h0007);
        rd(REG_RATE, 16'h0005);
        rd(REG_FORMAT, 16'h0005);
        // Restart the loss timer, which has been running since reset.
        send(8'h05, 1'b0, 16'h0000);
        wr(REG_TIMEOUT, 16'h0004);
        wr(REG_INT_MASK, 16'h0001);
        for (int a = 0; a < 4; a++) begin
            wr(REG_ACTION, 16'(a));
            send(8'h05, 1'b0, 16'h1230 + 16'(a));
            tick(4);
            send(8'h06, 1'b0, 16'h1230 + 16'(a));
            check(17'(resp), 17'h0);
            tick(14);
            check(17'(resp), {11'h0, 2'b11, a==0, a<2, a==2, a==3});
            check({1'b0, O_SPEED_REF}, {1'b0, 16'h1230 + 16'(a)});
            rd(REG_STATUS, {7'h0, 3'h5, 3'h5, 1'b0, a==0, 1'b1});
            send(8'h05, 1'b0, 16'h1230 + 16'(a));
            tick(1);
            check(17'(resp), {11'h0, 2'b01, a==0, 3'h0});
            rd(REG_INT_STAT, 16'h0005);
            wr(REG_CONTROL, 16'h0001);
            wr(REG_INT_STAT, 16'h0007);
            tick(1);
            check(17'(resp), 17'h0);
        end
        wr(REG_INT_MASK, 16'h0000);
        tick(24);
        check(17'(resp), 17'h00021);
        wr(REG_TIMEOUT, 16'hffff);
        rd(REG_TIMEOUT, 16'h0258);
        send(8'h05, 1'b0, 16'h0042);
        send(8'h05, 1'b1, 16'h0042);
        send(8'h05, 1'b1, 16'h0042);
        check(17'(resp), 17'h0);
        send(8'h05, 1'b1, 16'h0042);
        tick(4);
        check(17'(resp), 17'h00021);
        rd(REG_INT_STAT, 16'h0007);
        rd(REG_INT_MASK, 16'h0000);
        rd(REG_ACT_ADDR, 16'h0005);
        rd(REG_SPEED, 16'h0042);
        finish_test();
    end
endmodule

bind serial_port_loss_supervisor serial_port_loss_supervisor_sva
    #(.TICK_CYCLES(TICK_CYCLES), .ERR_LIMIT(ERR_LIMIT)) chk (
    .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_POWER_UP(I_POWER_UP),
    .I_FRAME_OK(I_FRAME_OK), .I_FRAME_ADDR(I_FRAME_ADDR),
    .I_FRAME_ERR(I_FRAME_ERR), .O_BIT_CYCLES(O_BIT_CYCLES),
    .O_PARITY_EN(O_PARITY_EN), .O_PARITY_ODD(O_PARITY_ODD),
    .O_TWO_STOP(O_TWO_STOP), .O_NODE_ADDR(O_NODE_ADDR),
    .O_COAST_STOP(O_COAST_STOP), .O_RAMP_STOP(O_RAMP_STOP),
    .O_HOLD_SPEED(O_HOLD_SPEED), .O_LINK_LOSS_FAULT(O_LINK_LOSS_FAULT),
    .O_LOSS_ACTIVE(O_LOSS_ACTIVE));
